// ---- logic/mfc_consts.svh ----
// Constants for the flow-control and link-fault block
`ifndef MFC_CONSTS_SVH
`define MFC_CONSTS_SVH
// ====
// Register byte offsets
`define MFC_OFF_CTRL 8'h00
`define MFC_OFF_SW_PFC 8'h04
`define MFC_OFF_PAUSE_EN 8'h08
`define MFC_OFF_HOLDOFF 8'h0C
`define MFC_OFF_DADDR_LO 8'h10
`define MFC_OFF_DADDR_HI 8'h14
`define MFC_OFF_LF_CFG 8'h18
`define MFC_OFF_STATUS 8'h1C
// ====
// Control register bits
`define MFC_CTRL_SW_PAUSE 0
`define MFC_CTRL_HOLDOFF_EN 1
`define MFC_CTRL_FWD_EN 2
`define MFC_CTRL_AUTO_STOP 3
// ====
// Reset values
`define MFC_RST_PAUSE_EN 8'hFF
`define MFC_RST_HOLDOFF 16'hFFFF
`define MFC_RST_LF_CFG 2'b00
// ====
// Frame matching
`define MFC_ETYPE_CTL 16'h8808
`define MFC_OPC_PAUSE 16'h0001
`define MFC_OPC_PFC 16'h0101
`define MFC_PAUSE_CLASS 0
// ====
// Link fault
`define MFC_SEQ_LOCAL 2'b01
`define MFC_SEQ_REMOTE 2'b10
`define MFC_LF_EN_BIT 0
`define MFC_LF_IPG_MODE 2'b11
`define MFC_SEQ_NEEDED 3'd4
`define MFC_COL_WINDOW 8'd128
`define MFC_DATA_COLS 8'd127
// ====
// Timing
`define MFC_QUANTA_BITS 512
`define MFC_BITS_PER_CYCLE 64
`define MFC_QUANTA_CYCLES (`MFC_QUANTA_BITS / `MFC_BITS_PER_CYCLE)
`endif

// ---- logic/mfc_pkg.sv ----
// Types shared by the flow-control and link-fault block
package mfc_pkg;
    typedef enum logic [1:0] {
        MFC_LF_OK,
        MFC_LF_LOCAL,
        MFC_LF_REMOTE
    } mfc_lf_state_t;
    typedef struct packed {
        logic is_pfc;
        logic pause_xoff;
        logic [7:0] cls_xoff;
        logic [7:0] cls_xon;
    } mfc_txreq_t;
    typedef struct packed {
        logic [47:0] dest;
        logic [15:0] ltype;
        logic [15:0] opcode;
        logic [15:0] quanta;
        logic [7:0] cls_en;
        logic [7:0] cls_xoff;
    } mfc_rxhdr_t;
    typedef struct packed {
        logic valid;
        logic is_seq;
        logic [1:0] fault;
        logic is_data;
    } mfc_col_t;
    typedef struct packed {
        logic send_rf;
        logic send_idle;
        logic ipg_only;
    } mfc_lftx_t;
endpackage

// ---- logic/mfc_top.sv ----
// Flow-control generation/filtering and link-fault logic of a MAC
// Function
// - Flow control present unless configured off
// - Client pause request sends one XOFF
// - Eight-bit class request sends PFC XOFF
// - Software request registers request XOFF frames
// - Hold-off timer repeats XOFF while requested
// - No extra XOFF while request held with hold-off disabled
// - Pause request release sends XON
// - Class release sends XON, combined
// - Clearing software pause sends XON
// - First XOFF only if class enabled
// - Received PAUSE may halt transmit
// - Matched pause request sets class indication
// - Match address, type and opcode
// - Forwarding on passes control frames
// - Forwarding off drops control frames
// - Act only on good length, FCS
// - Fault signaling off by default
// - Mode 11 sends sequences in gaps
// - Fault status set, cleared after data
// - Four same sequences set fault state
// - 128 quiet columns return OK
`include "mfc_consts.svh"
module mfc_top #(
    parameter bit FC_ENABLE = 1'b1,
    parameter int QUANTA_CYCLES = `MFC_QUANTA_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic tx_pause_req,
    input wire logic [7:0] tx_pfc_req,
    input wire logic tx_frame_busy,
    input wire logic fc_frame_ack,
    output logic fc_frame_valid,
    output mfc_pkg::mfc_txreq_t fc_frame,
    input wire logic rx_hdr_valid,
    input wire mfc_pkg::mfc_rxhdr_t rx_hdr,
    input wire logic rx_end,
    input wire logic rx_len_ok,
    input wire logic rx_fcs_ok,
    output logic rx_ctl_drop,
    output logic [7:0] rx_pause_ind,
    output logic tx_halt,
    input wire mfc_pkg::mfc_col_t rx_col,
    output mfc_pkg::mfc_lftx_t lf_tx
);
    // ====
    // Registers and state
    logic [3:0] ctrl_reg;
    logic [7:0] sw_pfc_reg;
    logic [7:0] pause_en_reg;
    logic [15:0] holdoff_reg;
    logic [47:0] daddr_reg;
    logic [1:0] lf_cfg_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic pause_lvl_reg;
    logic [7:0] pfc_lvl_reg;
    logic p_xoff_reg;
    logic p_xon_reg;
    logic [7:0] c_xoff_reg;
    logic [7:0] c_xon_reg;
    logic [15:0] p_hold_reg;
    logic [15:0] c_hold_reg;
    logic [15:0] qdiv_reg;
    logic ctl_match_reg;
    logic ctl_pfc_reg;
    mfc_pkg::mfc_rxhdr_t hdr_reg;
    logic [15:0] rx_timer_reg;
    mfc_pkg::mfc_lf_state_t lf_state_reg;
    logic [1:0] seq_type_reg;
    logic [2:0] seq_cnt_reg;
    logic [7:0] col_cnt_reg;
    logic [7:0] data_cnt_reg;
    logic lf_stat_reg;
    logic rf_stat_reg;
    // ====
    // Combinational terms
    logic quanta_tick;
    logic addr_phase;
    logic pause_lvl;
    logic [7:0] pfc_lvl;
    logic issue;
    logic p_xoff_set;
    logic [7:0] c_xoff_set;
    logic rx_act;
    logic seq_lf;
    logic fc_on;
    logic issue_pfc;
    logic hdr_match;

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            `MFC_OFF_CTRL: w[3:0] = ctrl_reg;
            `MFC_OFF_SW_PFC: w[7:0] = sw_pfc_reg;
            `MFC_OFF_PAUSE_EN: w[7:0] = pause_en_reg;
            `MFC_OFF_HOLDOFF: w[15:0] = holdoff_reg;
            `MFC_OFF_DADDR_LO: w = daddr_reg[31:0];
            `MFC_OFF_DADDR_HI: w[15:0] = daddr_reg[47:32];
            `MFC_OFF_LF_CFG: w[1:0] = lf_cfg_reg;
            `MFC_OFF_STATUS: w[15:0] = {rx_pause_ind, tx_halt, rf_stat_reg,
                lf_stat_reg, lf_state_reg, 3'b000};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    assign fc_on = FC_ENABLE;
    assign addr_phase = hsel && hready && htrans[1];
    assign quanta_tick = (qdiv_reg == 16'(QUANTA_CYCLES - 1));
    assign pause_lvl = fc_on && (tx_pause_req || ctrl_reg[`MFC_CTRL_SW_PAUSE]);
    assign pfc_lvl = fc_on ? (tx_pfc_req | sw_pfc_reg) : 8'h00;
    assign issue = !fc_frame_valid && !tx_frame_busy &&
        (p_xoff_reg || p_xon_reg || (|c_xoff_reg) || (|c_xon_reg));
    assign issue_pfc = issue && !p_xoff_reg && !p_xon_reg;
    // ====
    // AHB-Lite slave
    // MAC clock, async reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            // Zero wait states
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[7:0];
                hrdata <= hwrite ? 32'h0000_0000 : rd_word(haddr[7:0]);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= 4'h0;
            sw_pfc_reg <= 8'h00;
            pause_en_reg <= `MFC_RST_PAUSE_EN;
            holdoff_reg <= `MFC_RST_HOLDOFF;
            daddr_reg <= 48'h0000_0000_0000;
            lf_cfg_reg <= `MFC_RST_LF_CFG;
        end else if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                `MFC_OFF_CTRL: ctrl_reg <= hwdata[3:0];
                `MFC_OFF_SW_PFC: sw_pfc_reg <= hwdata[7:0];
                `MFC_OFF_PAUSE_EN: pause_en_reg <= hwdata[7:0];
                `MFC_OFF_HOLDOFF: holdoff_reg <= hwdata[15:0];
                `MFC_OFF_DADDR_LO: daddr_reg[31:0] <= hwdata;
                `MFC_OFF_DADDR_HI: daddr_reg[47:32] <= hwdata[15:0];
                `MFC_OFF_LF_CFG: lf_cfg_reg <= hwdata[1:0];
                default: ;
            endcase
        end
    end
    // ====
    // Quanta divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qdiv_reg <= 16'h0000;
        end else begin
            qdiv_reg <= quanta_tick ? 16'h0000 : qdiv_reg + 16'h0001;
        end
    end
    // ====
    // Transmit request tracking
    always_comb begin
        p_xoff_set = pause_lvl && !pause_lvl_reg && pause_en_reg[`MFC_PAUSE_CLASS];
        c_xoff_set = pfc_lvl & ~pfc_lvl_reg & pause_en_reg;
        if (ctrl_reg[`MFC_CTRL_HOLDOFF_EN] && pause_lvl && pause_lvl_reg &&
            quanta_tick && p_hold_reg == 16'h0001) begin
            p_xoff_set = 1'b1;
        end
        if (ctrl_reg[`MFC_CTRL_HOLDOFF_EN] && quanta_tick && c_hold_reg == 16'h0001) begin
            c_xoff_set = c_xoff_set | (pfc_lvl & pfc_lvl_reg & pause_en_reg);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pause_lvl_reg <= 1'b0;
            pfc_lvl_reg <= 8'h00;
            p_xoff_reg <= 1'b0;
            p_xon_reg <= 1'b0;
            c_xoff_reg <= 8'h00;
            c_xon_reg <= 8'h00;
        end else begin
            pause_lvl_reg <= pause_lvl;
            pfc_lvl_reg <= pfc_lvl;
            // New requests win over the issue clear
            if (issue) begin
                p_xoff_reg <= p_xoff_set;
                p_xon_reg <= 1'b0;
            end else begin
                p_xoff_reg <= p_xoff_reg || p_xoff_set;
            end
            c_xoff_reg <= (issue_pfc ? 8'h00 : c_xoff_reg) | c_xoff_set;
            if (issue_pfc) begin
                c_xon_reg <= 8'h00;
            end
            if (!pause_lvl && pause_lvl_reg) begin
                p_xon_reg <= 1'b1;
                p_xoff_reg <= 1'b0;
            end
            if (|(~pfc_lvl & pfc_lvl_reg)) begin
                c_xon_reg <= (issue_pfc ? 8'h00 : c_xon_reg) | (~pfc_lvl & pfc_lvl_reg);
                c_xoff_reg <= ((issue_pfc ? 8'h00 : c_xoff_reg) | c_xoff_set) & pfc_lvl;
            end
        end
    end
    // ====
    // Control frame issue to the transmitter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fc_frame_valid <= 1'b0;
            fc_frame <= '0;
        end else if (fc_frame_valid) begin
            if (fc_frame_ack) begin
                fc_frame_valid <= 1'b0;
            end
        end else if (issue) begin
            fc_frame_valid <= 1'b1;
            // PAUSE goes first; class work waits for the next slot
            if (p_xoff_reg || p_xon_reg) begin
                fc_frame.is_pfc <= 1'b0;
                fc_frame.pause_xoff <= p_xoff_reg;
                fc_frame.cls_xoff <= 8'h00;
                fc_frame.cls_xon <= 8'h00;
            end else begin
                fc_frame.is_pfc <= 1'b1;
                fc_frame.pause_xoff <= 1'b0;
                fc_frame.cls_xoff <= c_xoff_reg;
                fc_frame.cls_xon <= c_xon_reg;
            end
        end
    end
    // ====
    // Hold-off timers, started when an XOFF leaves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            p_hold_reg <= 16'h0000;
            c_hold_reg <= 16'h0000;
        end else begin
            if (fc_frame_valid && fc_frame_ack && !fc_frame.is_pfc && fc_frame.pause_xoff) begin
                p_hold_reg <= holdoff_reg;
            end else if (quanta_tick && p_hold_reg != 16'h0000) begin
                p_hold_reg <= p_hold_reg - 16'h0001;
            end
            if (fc_frame_valid && fc_frame_ack && fc_frame.is_pfc && (|fc_frame.cls_xoff)) begin
                c_hold_reg <= holdoff_reg;
            end else if (quanta_tick && c_hold_reg != 16'h0000) begin
                c_hold_reg <= c_hold_reg - 16'h0001;
            end
        end
    end
    // ====
    // Receive control frame filter
    // address, type and opcode
    assign hdr_match = fc_on && rx_hdr.dest == daddr_reg && rx_hdr.ltype == `MFC_ETYPE_CTL &&
        (rx_hdr.opcode == `MFC_OPC_PAUSE || rx_hdr.opcode == `MFC_OPC_PFC);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_match_reg <= 1'b0;
            ctl_pfc_reg <= 1'b0;
            hdr_reg <= '0;
            rx_ctl_drop <= 1'b0;
        end else if (rx_hdr_valid) begin
            ctl_match_reg <= hdr_match;
            ctl_pfc_reg <= rx_hdr.opcode == `MFC_OPC_PFC;
            hdr_reg <= rx_hdr;
            rx_ctl_drop <= !ctrl_reg[`MFC_CTRL_FWD_EN] && hdr_match;
        end else if (rx_end) begin
            ctl_match_reg <= 1'b0;
        end
    end

    assign rx_act = rx_end && ctl_match_reg && rx_len_ok && rx_fcs_ok;
    // ====
    // Received pause action
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_pause_ind <= 8'h00;
            rx_timer_reg <= 16'h0000;
            tx_halt <= 1'b0;
        end else begin
            if (rx_act && !ctl_pfc_reg) begin
                rx_timer_reg <= hdr_reg.quanta;
            end else if (quanta_tick && rx_timer_reg != 16'h0000) begin
                rx_timer_reg <= rx_timer_reg - 16'h0001;
            end
            if (rx_act && ctl_pfc_reg) begin
                rx_pause_ind <= (rx_pause_ind & ~hdr_reg.cls_en) |
                    (hdr_reg.cls_en & hdr_reg.cls_xoff);
            end else if (rx_act) begin
                rx_pause_ind <= (hdr_reg.quanta != 16'h0000) ? 8'hFF : 8'h00;
            end else if (!ctl_pfc_reg && rx_timer_reg == 16'h0000 && tx_halt) begin
                rx_pause_ind <= 8'h00;
            end
            tx_halt <= ctrl_reg[`MFC_CTRL_AUTO_STOP] && rx_timer_reg != 16'h0000;
        end
    end
    // ====
    // Link fault detection
    assign seq_lf = rx_col.valid && rx_col.is_seq &&
        (rx_col.fault == `MFC_SEQ_LOCAL || rx_col.fault == `MFC_SEQ_REMOTE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lf_state_reg <= mfc_pkg::MFC_LF_OK;
            seq_type_reg <= 2'b00;
            seq_cnt_reg <= 3'd0;
            col_cnt_reg <= 8'd0;
        end else if (seq_lf) begin
            col_cnt_reg <= 8'd0;
            seq_type_reg <= rx_col.fault;
            if (rx_col.fault != seq_type_reg || seq_cnt_reg == 3'd0) begin
                seq_cnt_reg <= 3'd1;
            end else if (seq_cnt_reg + 3'd1 >= `MFC_SEQ_NEEDED) begin
                seq_cnt_reg <= `MFC_SEQ_NEEDED;
                lf_state_reg <= (rx_col.fault == `MFC_SEQ_LOCAL) ?
                    mfc_pkg::MFC_LF_LOCAL : mfc_pkg::MFC_LF_REMOTE;
            end else begin
                seq_cnt_reg <= seq_cnt_reg + 3'd1;
            end
        end else if (rx_col.valid) begin
            if (col_cnt_reg == `MFC_COL_WINDOW - 8'd1) begin
                col_cnt_reg <= 8'd0;
                seq_cnt_reg <= 3'd0;
                lf_state_reg <= mfc_pkg::MFC_LF_OK;
            end else begin
                col_cnt_reg <= col_cnt_reg + 8'd1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lf_stat_reg <= 1'b0;
            rf_stat_reg <= 1'b0;
            data_cnt_reg <= 8'd0;
        end else if (seq_lf) begin
            data_cnt_reg <= 8'd0;
            lf_stat_reg <= lf_stat_reg || rx_col.fault == `MFC_SEQ_LOCAL;
            rf_stat_reg <= rf_stat_reg || rx_col.fault == `MFC_SEQ_REMOTE;
        end else if (rx_col.valid && rx_col.is_data) begin
            if (data_cnt_reg == `MFC_DATA_COLS) begin
                lf_stat_reg <= 1'b0;
                rf_stat_reg <= 1'b0;
            end else begin
                data_cnt_reg <= data_cnt_reg + 8'd1;
            end
        end
    end
    // ====
    // Link fault transmit control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lf_tx <= '0;
        end else begin
            // local gives RF, remote gives idle
            lf_tx.send_rf <= lf_cfg_reg[`MFC_LF_EN_BIT] &&
                lf_state_reg == mfc_pkg::MFC_LF_LOCAL;
            lf_tx.send_idle <= lf_cfg_reg[`MFC_LF_EN_BIT] &&
                lf_state_reg == mfc_pkg::MFC_LF_REMOTE;
            lf_tx.ipg_only <= lf_cfg_reg == `MFC_LF_IPG_MODE;
        end
    end
endmodule

// ---- verification/mfc_chk.sv ----
// Assertion checker for the flow-control and link-fault block
module mfc_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic tx_frame_busy,
    input wire logic fc_frame_ack,
    input wire logic fc_frame_valid,
    input wire mfc_pkg::mfc_txreq_t fc_frame,
    input wire logic rx_hdr_valid,
    input wire mfc_pkg::mfc_rxhdr_t rx_hdr,
    input wire logic rx_end,
    input wire logic rx_ctl_drop,
    input wire logic [7:0] rx_pause_ind,
    input wire logic tx_halt,
    input wire mfc_pkg::mfc_lftx_t lf_tx
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ====
    // Bus and transmit requests
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    ready_high_a: assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout low after reset");
    frame_hold_a: assert property (
        fc_frame_valid && !fc_frame_ack |=> fc_frame_valid && $stable(fc_frame))
        else $error("control frame changed before ack");
    ack_drop_a: assert property (fc_frame_valid && fc_frame_ack |=> !fc_frame_valid)
        else $error("control frame still valid after ack");
    // No offer during a data frame
    wait_busy_a: assert property ($rose(fc_frame_valid) |-> $past(!tx_frame_busy))
        else $error("control frame offered during data frame");
    // ====
    // Receive filter and link fault
    type_filter_a: assert property (
        rx_hdr_valid && rx_hdr.ltype != 16'h8808 |=> !rx_ctl_drop)
        else $error("wrong type dropped");
    opcode_filter_a: assert property (
        rx_hdr_valid && rx_hdr.opcode != 16'h0001 && rx_hdr.opcode != 16'h0101 |=> !rx_ctl_drop)
        else $error("wrong opcode dropped");
    halt_cause_a: assert property ($rose(tx_halt) |-> $past(rx_end, 2))
        else $error("halt without received frame");
    ind_cause_a: assert property (
        (rx_pause_ind & ~$past(rx_pause_ind)) != 8'h00 |-> $past(rx_end))
        else $error("pause indication without frame end");
    lf_excl_a: assert property (!(lf_tx.send_rf && lf_tx.send_idle))
        else $error("remote fault and idle sent together");
    cover property (fc_frame_valid && fc_frame_ack && fc_frame.is_pfc);
    cover property ($rose(tx_halt));
    cover property (rx_hdr_valid ##1 rx_ctl_drop);
endmodule

bind mfc_top mfc_chk mfc_chk_inst (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .tx_frame_busy(tx_frame_busy), .fc_frame_ack(fc_frame_ack),
    .fc_frame_valid(fc_frame_valid), .fc_frame(fc_frame), .rx_hdr_valid(rx_hdr_valid),
    .rx_hdr(rx_hdr), .rx_end(rx_end), .rx_ctl_drop(rx_ctl_drop),
    .rx_pause_ind(rx_pause_ind), .tx_halt(tx_halt), .lf_tx(lf_tx)
);

// ---- verification/mfc_tx_model.sv ----
// Transmitter model that sends data frames and takes control frames
module mfc_tx_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fc_frame_valid,
    input wire logic slow,
    input wire logic data_go,
    output logic tx_frame_busy,
    output logic fc_frame_ack
);
    logic [3:0] wait_reg;
    logic [4:0] busy_reg;
    assign tx_frame_busy = busy_reg != 5'h00;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_reg <= 4'h0;
            busy_reg <= 5'h00;
            fc_frame_ack <= 1'b0;
        end else begin
            fc_frame_ack <= 1'b0;
            // Acks only between data frames
            if (fc_frame_valid && !fc_frame_ack && !tx_frame_busy) begin
                wait_reg <= wait_reg + 4'h1;
                if (wait_reg >= (slow ? 4'h6 : 4'h0)) begin
                    fc_frame_ack <= 1'b1;
                    wait_reg <= 4'h0;
                end
            end
            if (data_go && !fc_frame_valid && !tx_frame_busy) begin
                busy_reg <= 5'h14;
            end else if (tx_frame_busy) begin
                busy_reg <= busy_reg - 5'h01;
            end
        end
    end
endmodule

// ---- verification/mfc_tb.sv ----
// Self-checking testbench for the flow-control and link-fault block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_pause_req = 1'b0;
    logic rx_hdr_valid = 1'b0, rx_end = 1'b0, rx_len_ok = 1'b1, rx_fcs_ok = 1'b1;
    logic slow = 1'b0, data_go = 1'b0, dp_rd = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, seed = 32'h0000_0009;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic [7:0] tx_pfc_req = 8'h00;
    mfc_pkg::mfc_rxhdr_t rx_hdr = '0;
    mfc_pkg::mfc_col_t rx_col = '0;
    logic hready, hreadyout, hresp, tx_frame_busy, fc_frame_ack, fc_frame_valid;
    logic rx_ctl_drop, tx_halt;
    logic [31:0] hrdata;
    logic [7:0] rx_pause_ind;
    mfc_pkg::mfc_txreq_t fc_frame;
    mfc_pkg::mfc_lftx_t lf_tx;
    logic [31:0] exp_rd[$];
    logic [17:0] exp_fc[$];
    int fails = 0, n_checks = 0, cycles = 0;
    localparam logic [4:0] C_IDLE = 5'h10, C_LOC = 5'h1A, C_REM = 5'h1C, C_DATA = 5'h11;
    assign hready = hreadyout;
    mfc_top #(.QUANTA_CYCLES(1)) mfc_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_pause_req(tx_pause_req),
        .tx_pfc_req(tx_pfc_req), .tx_frame_busy(tx_frame_busy), .fc_frame_ack(fc_frame_ack),
        .fc_frame_valid(fc_frame_valid), .fc_frame(fc_frame), .rx_hdr_valid(rx_hdr_valid),
        .rx_hdr(rx_hdr), .rx_end(rx_end), .rx_len_ok(rx_len_ok), .rx_fcs_ok(rx_fcs_ok),
        .rx_ctl_drop(rx_ctl_drop), .rx_pause_ind(rx_pause_ind), .tx_halt(tx_halt),
        .rx_col(rx_col), .lf_tx(lf_tx)
    );
    mfc_tx_model mfc_tx_model_inst (
        .hclk(hclk), .hresetn(hresetn), .fc_frame_valid(fc_frame_valid), .slow(slow),
        .data_go(data_go), .tx_frame_busy(tx_frame_busy), .fc_frame_ack(fc_frame_ack)
    );
    initial begin
        forever #25 hclk = ~hclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ====
    // Result monitor
    always @(posedge hclk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            print_verdict();
        end
        if (dp_rd && hreadyout) begin
            check(hrdata, exp_rd.size() != 0 ? exp_rd.pop_front() : 32'hFFFF_FFFF);
        end
        dp_rd <= hsel && htrans[1] && !hwrite && hreadyout;
        if (fc_frame_valid && fc_frame_ack) begin
            check({14'h0000, fc_frame}, exp_fc.size() != 0 ?
                {14'h0000, exp_fc.pop_front()} : 32'hFFFF_FFFF);
        end
    end
    // ====
    // Drivers
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        ahb(1'b0, a, 32'h0000_0000);
    endtask
    // Bounded wait: a lost frame fails
    task automatic wait_fc();
        for (int i = 0; i < 300 && exp_fc.size() != 0; i++) begin
            @(posedge hclk);
        end
        check(exp_fc.size(), 0);
        @(posedge hclk);
    endtask
    task automatic col(input logic [4:0] c, input int n);
        repeat (n) begin
            rx_col <= c;
            @(posedge hclk);
        end
    endtask
    task automatic seqs(input logic [4:0] c, input int n);
        repeat (n) begin
            col(c, 1);
            col(C_IDLE, 8);
        end
    endtask
    task automatic rxf(input logic [7:0] da, input logic [15:0] lt, input logic [15:0] op,
                       input logic [7:0] ce, input logic ok);
        rx_hdr <= {40'h9A_BC12_3456, da, lt, op, 16'h00FF, ce, ce};
        rx_hdr_valid <= 1'b1;
        @(posedge hclk);
        rx_hdr_valid <= 1'b0;
        @(posedge hclk);
        rx_end <= 1'b1;
        rx_fcs_ok <= ok;
        rx_len_ok <= ok;
        @(posedge hclk);
        rx_end <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    // ====
    // Main sequence
    initial begin
        logic [7:0] m;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h08, 32'h0000_00FF);
        rd(8'h0C, 32'h0000_FFFF);
        rd(8'h18, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        wr(8'h10, 32'h1234_5678);
        wr(8'h14, 32'h0000_9ABC);
        rd(8'h10, 32'h1234_5678);
        exp_fc.push_back({2'b01, 16'h0000});
        data_go <= 1'b1;
        @(posedge hclk);
        data_go <= 1'b0;
        tx_pause_req <= 1'b1;
        wait_fc();
        exp_fc.push_back({2'b00, 16'h0000});
        tx_pause_req <= 1'b0;
        wait_fc();
        slow <= 1'b1;
        repeat (3) begin
            seed = xs(seed);
            m = seed[7:0] | 8'h01;
            exp_fc.push_back({2'b10, m, 8'h00});
            tx_pfc_req <= m;
            wait_fc();
            exp_fc.push_back({2'b10, 8'h00, m});
            tx_pfc_req <= 8'h00;
            wait_fc();
        end
        slow <= 1'b0;
        exp_fc.push_back({2'b01, 16'h0000});
        wr(8'h00, 32'h0000_0001);
        wait_fc();
        exp_fc.push_back({2'b00, 16'h0000});
        wr(8'h00, 32'h0000_0000);
        wait_fc();
        wr(8'h0C, 32'h0000_0008);
        wr(8'h00, 32'h0000_0002);
        repeat (3) exp_fc.push_back({2'b01, 16'h0000});
        tx_pause_req <= 1'b1;
        wait_fc();
        exp_fc.push_back({2'b00, 16'h0000});
        tx_pause_req <= 1'b0;
        wait_fc();
        wr(8'h00, 32'h0000_0000);
        exp_fc.push_back({2'b10, 8'h30, 8'h00});
        wr(8'h04, 32'h0000_0030);
        wait_fc();
        seqs(C_LOC, 3);
        seqs(C_REM, 1);
        rd(8'h1C, 32'h0000_0060);
        seqs(C_LOC, 4);
        rd(8'h1C, 32'h0000_0068);
        check(lf_tx, 32'h0000_0000);
        wr(8'h18, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        check(lf_tx, 32'h0000_0004);
        wr(8'h18, 32'h0000_0003);
        repeat (3) @(posedge hclk);
        check(lf_tx, 32'h0000_0005);
        col(C_IDLE, 130);
        rd(8'h1C, 32'h0000_0060);
        col(C_DATA, 128);
        col(C_IDLE, 2);
        rd(8'h1C, 32'h0000_0000);
        wr(8'h00, 32'h0000_0008);
        rxf(8'h78, 16'h8808, 16'h0101, 8'h04, 1'b1);
        check(rx_ctl_drop, 1'b1);
        check(rx_pause_ind, 8'h04);
        check(tx_halt, 1'b0);
        rxf(8'h78, 16'h8808, 16'h0101, 8'h20, 1'b0);
        check(rx_pause_ind[5], 1'b0);
        rxf(8'h78, 16'h8808, 16'h0001, 8'h00, 1'b1);
        check(rx_pause_ind[0], 1'b1);
        check(tx_halt, 1'b1);
        rxf(8'h78, 16'h0800, 16'h0001, 8'h00, 1'b1);
        check(rx_ctl_drop, 1'b0);
        rxf(8'h78, 16'h8808, 16'h0002, 8'h00, 1'b1);
        check(rx_ctl_drop, 1'b0);
        rxf(8'h79, 16'h8808, 16'h0001, 8'h00, 1'b1);
        check(rx_ctl_drop, 1'b0);
        wr(8'h00, 32'h0000_000C);
        rxf(8'h78, 16'h8808, 16'h0001, 8'h00, 1'b1);
        check(rx_ctl_drop, 1'b0);
        wr(8'h08, 32'h0000_000F);
        tx_pfc_req <= 8'hC0;
        repeat (20) @(posedge hclk);
        check(fc_frame_valid, 1'b0);
        check(exp_rd.size(), 0);
        print_verdict();
    end
endmodule
